// *** rtl/dsof_flags.sv ***
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

module dsof_flags #(
    parameter int N_DO = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsof_pkg::ADDR_W-1:0] paddr,
    input wire logic [dsof_pkg::DATA_W-1:0] pwdata,
    output logic [dsof_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dsof_pkg::dsof_cond_t cond,
    input wire logic proc_cmd_start,
    input wire logic proc_cmd_end,
    output dsof_pkg::dsof_flags_t flags,
    output logic [N_DO-1:0] do_pin,
    output logic internal_procedure_mode
);
    import dsof_pkg::*;

    // refuse pin counts the routing cannot serve
    if (N_DO < 1 || N_DO > 8) begin : g_bad_n_do
        $error("N_DO must lie between 1 and 8");
    end

    function automatic logic flag_of_code(input logic [CODE_W-1:0] code, input dsof_flags_t f);
        logic v;
        v = 1'b0;
        case (code)
            CODE_OVERLOAD_WARNING: v = f.overload_warning_flag;
            CODE_WARNING: v = f.warning_flag;
            CODE_COMMAND_OVERFLOW: v = f.command_overflow_flag;
            CODE_REVERSE_SOFT_LIMIT: v = f.reverse_soft_limit_flag;
            CODE_FORWARD_SOFT_LIMIT: v = f.forward_soft_limit_flag;
            CODE_COMMAND_COMPLETED: v = f.command_completed_flag;
            CODE_CAPTURE_COMPLETED: v = f.capture_completed_flag;
            CODE_MOTION_COMPLETED: v = f.motion_completed_flag;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : flag_of_code

    function automatic logic sel_hit(input logic [ADDR_W-1:0] a, input int idx);
        return a == SEL_BASE_OFFSET + ADDR_W'(4 * idx);
    endfunction : sel_hit

    // ---------------- register bus
    logic [CODE_W-1:0] sel [N_DO];
    logic [CODE_W-1:0] next_sel [N_DO];
    logic next_mode;
    logic [DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic setup;
    logic wr_access;
    logic mapped;

    assign setup = psel && !penable;
    // zero-wait slave: every access phase completes at once
    assign pready = psel && penable;
    assign wr_access = psel && penable && pwrite;

    always_comb begin
        mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
        for (int i = 0; i < N_DO; i++) begin
            if (sel_hit(paddr, i)) begin
                mapped = 1'b1;
            end
        end
        next_mode = internal_procedure_mode;
        for (int i = 0; i < N_DO; i++) begin
            next_sel[i] = sel[i];
        end
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = !mapped || (pwrite && paddr == STATUS_OFFSET);
            next_prdata = '0;
            if (!pwrite) begin
                if (paddr == CTRL_OFFSET) begin
                    next_prdata[CTRL_MODE_BIT] = internal_procedure_mode;
                end else if (paddr == STATUS_OFFSET) begin
                    next_prdata[FLAGS_W-1:0] = flags;
                end
                for (int i = 0; i < N_DO; i++) begin
                    if (sel_hit(paddr, i)) begin
                        next_prdata[CODE_W-1:0] = sel[i];
                    end
                end
            end
        end
        if (wr_access && !pslverr) begin
            if (paddr == CTRL_OFFSET) begin
                next_mode = pwdata[CTRL_MODE_BIT];
            end
            for (int i = 0; i < N_DO; i++) begin
                if (sel_hit(paddr, i)) begin
                    next_sel[i] = pwdata[CODE_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_procedure_mode <= CTRL_MODE_RESET;
            prdata <= '0;
            pslverr <= 1'b0;
            for (int i = 0; i < N_DO; i++) begin
                sel[i] <= SEL_RESET;
            end
        end else begin
            internal_procedure_mode <= next_mode;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            for (int i = 0; i < N_DO; i++) begin
                sel[i] <= next_sel[i];
            end
        end
    end

    // ---------------- command completion tracking
    dsof_cmd_state_t cmd_state;
    dsof_cmd_state_t next_cmd_state;

    always_comb begin
        next_cmd_state = cmd_state;
        case (cmd_state)
            DSOF_CMD_IDLE: begin
                if (proc_cmd_start) begin
                    next_cmd_state = DSOF_CMD_RUN;
                end
            end
            DSOF_CMD_RUN: begin
                if (proc_cmd_end && !proc_cmd_start) begin
                    next_cmd_state = DSOF_CMD_DONE;
                end
            end
            DSOF_CMD_DONE: begin
                if (proc_cmd_start) begin
                    next_cmd_state = DSOF_CMD_RUN;
                end
            end
            default: next_cmd_state = DSOF_CMD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_state <= DSOF_CMD_IDLE;
        end else begin
            cmd_state <= next_cmd_state;
        end
    end

    // ---------------- flag generation
    dsof_flags_t next_flags;
    logic warn_src;

    assign warn_src = cond.rev_limit_err || cond.fwd_limit_err || cond.emergency_stop ||
        cond.comm_err || cond.undervoltage;

    always_comb begin
        next_flags.overload_warning_flag = cond.overload_accum_met;
        // fault sources; warning class only once warning shows
        next_flags.servo_fault_flag = cond.overload_alarm_code || cond.other_fault ||
            (warn_src && flags.warning_flag);
        next_flags.warning_flag = warn_src;
        next_flags.command_overflow_flag = cond.cmd_overflow_det;
        next_flags.reverse_soft_limit_flag = cond.rev_soft_limit_hit;
        next_flags.forward_soft_limit_flag = cond.fwd_soft_limit_hit;
        // from command state only, procedure mode
        next_flags.command_completed_flag = internal_procedure_mode &&
            (next_cmd_state == DSOF_CMD_DONE);
        next_flags.capture_completed_flag = internal_procedure_mode && cond.capture_done;
        next_flags.motion_completed_flag = next_flags.command_completed_flag &&
            cond.in_position_flag;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ---------------- digital output routing
    logic [N_DO-1:0] next_do_pin;

    generate
        for (genvar g = 0; g < N_DO; g++) begin : g_do
            assign next_do_pin[g] = flag_of_code(sel[g], next_flags);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            do_pin <= '0;
        end else begin
            do_pin <= next_do_pin;
        end
    end

    // ---------------- assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // flops sit in reset on the release edge, so checks gated by $past(presetn) start one edge later
    property p_ovl_warn;
        $past(presetn) && cond.overload_accum_met |=> flags.overload_warning_flag;
    endproperty
    a_ovl_warn: assert property (p_ovl_warn) else $error("overload warning missed");

    property p_ovl_fault;
        $past(presetn) && cond.overload_alarm_code |=> flags.servo_fault_flag;
    endproperty
    a_ovl_fault: assert property (p_ovl_fault) else $error("overload alarm gave no fault");

    property p_warn;
        $past(presetn) && warn_src |=> flags.warning_flag;
    endproperty
    a_warn: assert property (p_warn) else $error("warning missed");

    property p_cmd_overflow;
        $past(presetn) |-> flags.command_overflow_flag == $past(cond.cmd_overflow_det);
    endproperty
    a_cmd_overflow: assert property (p_cmd_overflow) else $error("overflow flag wrong");

    property p_rev;
        ($past(presetn) && cond.rev_soft_limit_hit) ##1 !cond.rev_soft_limit_hit
            |-> flags.reverse_soft_limit_flag
            ##1 !flags.reverse_soft_limit_flag;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse limit flag wrong");

    property p_fwd;
        $past(presetn) && cond.fwd_soft_limit_hit |=> flags.forward_soft_limit_flag;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward limit flag missed");

    property p_cmd_mode;
        flags.command_completed_flag |-> $past(internal_procedure_mode);
    endproperty
    a_cmd_mode: assert property (p_cmd_mode) else $error("command done outside mode");

    property p_cmd_run;
        proc_cmd_start |=> !flags.command_completed_flag;
    endproperty
    a_cmd_run: assert property (p_cmd_run) else $error("command done while running");

    property p_cmd_end;
        ($past(presetn) && proc_cmd_start) ##1
            (!proc_cmd_start && proc_cmd_end && internal_procedure_mode)
            |=> flags.command_completed_flag;
    endproperty
    a_cmd_end: assert property (p_cmd_end) else $error("command done not raised");

    property p_cmd_indep;
        flags.command_completed_flag && !proc_cmd_start && internal_procedure_mode
            |=> flags.command_completed_flag;
    endproperty
    a_cmd_indep: assert property (p_cmd_indep) else $error("command done dropped");

    property p_cap;
        flags.capture_completed_flag |-> $past(cond.capture_done) &&
            $past(internal_procedure_mode);
    endproperty
    a_cap: assert property (p_cap) else $error("capture flag without cause");

    property p_motion;
        flags.motion_completed_flag == (flags.command_completed_flag &&
            $past(cond.in_position_flag));
    endproperty
    a_motion: assert property (p_motion) else $error("motion flag not the AND");

    property p_fault_order;
        flags.servo_fault_flag && !$past(cond.overload_alarm_code) && !$past(cond.other_fault)
            |-> $past(flags.warning_flag);
    endproperty
    a_fault_order: assert property (p_fault_order) else $error("fault before warning");

    property p_level;
        !cond.overload_accum_met |=> !flags.overload_warning_flag;
    endproperty
    a_level: assert property (p_level) else $error("overload warning held");

    c_motion: cover property (flags.motion_completed_flag);
    c_fault_chain: cover property (flags.warning_flag ##1 flags.servo_fault_flag);
    c_cmd_cycle: cover property (flags.command_completed_flag ##1 !flags.command_completed_flag
        ##[1:20] flags.command_completed_flag);
    c_pin: cover property (do_pin[0] && sel[0] == CODE_MOTION_COMPLETED);

endmodule : dsof_flags

// *** rtl/dsof_pkg.sv ***
package dsof_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 6;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] SEL_BASE_OFFSET = 8'h10;

    // field positions and reset values
    localparam int CTRL_MODE_BIT = 0;
    localparam logic CTRL_MODE_RESET = 1'b0;
    localparam logic [CODE_W-1:0] SEL_RESET = 6'h00;

    // output selection codes
    localparam logic [CODE_W-1:0] CODE_OVERLOAD_WARNING = 6'h10;
    localparam logic [CODE_W-1:0] CODE_WARNING = 6'h11;
    localparam logic [CODE_W-1:0] CODE_COMMAND_OVERFLOW = 6'h12;
    localparam logic [CODE_W-1:0] CODE_REVERSE_SOFT_LIMIT = 6'h13;
    localparam logic [CODE_W-1:0] CODE_FORWARD_SOFT_LIMIT = 6'h14;
    localparam logic [CODE_W-1:0] CODE_COMMAND_COMPLETED = 6'h15;
    localparam logic [CODE_W-1:0] CODE_CAPTURE_COMPLETED = 6'h16;
    localparam logic [CODE_W-1:0] CODE_MOTION_COMPLETED = 6'h17;

    typedef struct packed {
        logic overload_accum_met;
        logic overload_alarm_code;
        logic rev_limit_err;
        logic fwd_limit_err;
        logic emergency_stop;
        logic comm_err;
        logic undervoltage;
        logic other_fault;
        logic cmd_overflow_det;
        logic rev_soft_limit_hit;
        logic fwd_soft_limit_hit;
        logic capture_done;
        logic in_position_flag;
    } dsof_cond_t;

    typedef struct packed {
        logic overload_warning_flag;
        logic servo_fault_flag;
        logic warning_flag;
        logic command_overflow_flag;
        logic reverse_soft_limit_flag;
        logic forward_soft_limit_flag;
        logic command_completed_flag;
        logic capture_completed_flag;
        logic motion_completed_flag;
    } dsof_flags_t;

    localparam int FLAGS_W = $bits(dsof_flags_t);
    localparam dsof_flags_t FLAGS_RESET = '0;

    typedef enum logic [1:0] {
        DSOF_CMD_IDLE = 2'b00,
        DSOF_CMD_RUN = 2'b01,
        DSOF_CMD_DONE = 2'b11
    } dsof_cmd_state_t;

endpackage : dsof_pkg

// *** verif/dsof_host_model.sv ***
`timescale 1ns/1ps

// plc input scan: outputs are read one cycle after they are driven
module dsof_host_model #(
    parameter int N_DO = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N_DO-1:0] do_pin,
    output logic [N_DO-1:0] seen_pins
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_pins <= '0;
        end else begin
            seen_pins <= do_pin;
        end
    end
endmodule : dsof_host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    import dsof_pkg::*;
    typedef struct packed {
        dsof_cond_t c;
        dsof_flags_t f;
    } dsof_row_t;
    localparam dsof_row_t ROWS [13] = '{
        {13'h1000, 9'h100}, {13'h0800, 9'h080}, {13'h0400, 9'h0c0}, {13'h0200, 9'h0c0},
        {13'h0100, 9'h0c0}, {13'h0080, 9'h0c0}, {13'h0040, 9'h0c0}, {13'h0020, 9'h080},
        {13'h0010, 9'h020}, {13'h0008, 9'h010}, {13'h0004, 9'h008}, {13'h0002, 9'h002},
        {13'h0001, 9'h000}
    };
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    dsof_cond_t cond = '0;
    logic proc_cmd_start = 1'b0;
    logic proc_cmd_end = 1'b0;
    dsof_flags_t flags;
    logic [3:0] do_pin;
    logic [3:0] seen_pins;
    logic [3:0] pin_want;
    logic [CODE_W-1:0] sel [4];
    logic internal_procedure_mode;
    int err_total = 0;
    int cmp_count = 0;

    always #20 pclk = ~pclk;

    dsof_flags #(.N_DO(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond(cond), .proc_cmd_start(proc_cmd_start),
        .proc_cmd_end(proc_cmd_end), .flags(flags), .do_pin(do_pin),
        .internal_procedure_mode(internal_procedure_mode)
    );

    dsof_host_model #(.N_DO(4)) host_u (
        .pclk(pclk), .presetn(presetn), .do_pin(do_pin), .seen_pins(seen_pins)
    );

    task wrap_up;
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : step

    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic pin_exp(input logic [CODE_W-1:0] code, input dsof_flags_t f);
        case (code)
            CODE_OVERLOAD_WARNING: return f.overload_warning_flag;
            CODE_WARNING: return f.warning_flag;
            CODE_COMMAND_OVERFLOW: return f.command_overflow_flag;
            CODE_REVERSE_SOFT_LIMIT: return f.reverse_soft_limit_flag;
            CODE_FORWARD_SOFT_LIMIT: return f.forward_soft_limit_flag;
            CODE_COMMAND_COMPLETED: return f.command_completed_flag;
            CODE_CAPTURE_COMPLETED: return f.capture_completed_flag;
            CODE_MOTION_COMPLETED: return f.motion_completed_flag;
            default: return 1'b0;
        endcase
    endfunction : pin_exp

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        step(1);
        check(33'(flags), 33'h0);
        apb(1'b0, CTRL_OFFSET, '0);
        check({er, rd}, 33'h0);
        apb(1'b0, SEL_BASE_OFFSET, '0);
        check({er, rd}, 33'h0);
        // unmapped place and read-only status are refused
        apb(1'b0, 8'h40, '0);
        check({er, rd}, {1'b1, 32'h0});
        apb(1'b1, STATUS_OFFSET, 32'h1ff);
        check(33'(er), 33'h1);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        apb(1'b0, CTRL_OFFSET, '0);
        check({er, rd}, 33'h1);
        check(33'(internal_procedure_mode), 33'h1); // mode on
        // third pass uses codes outside the table, pins stay low
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 4; i++) begin
                sel[i] = 6'(6'h10 + 4 * p + i);
                apb(1'b1, 8'(SEL_BASE_OFFSET + 4 * i), 32'(sel[i]));
                apb(1'b0, 8'(SEL_BASE_OFFSET + 4 * i), '0);
                check({er, rd}, 33'(sel[i]));
            end
            for (int r = 0; r < 13; r++) begin
                @(posedge pclk);
                cond <= ROWS[r].c;
                step(3);
                for (int i = 0; i < 4; i++) pin_want[i] = pin_exp(sel[i], ROWS[r].f);
                check(33'(flags), 33'(ROWS[r].f));
                check(33'(seen_pins), 33'(pin_want));
                apb(1'b0, STATUS_OFFSET, '0);
                check({er, rd}, 33'(ROWS[r].f)); // status read matches the flags
                @(posedge pclk);
                cond <= '0;
                step(3);
                check(33'(flags), 33'h0); // levels drop
            end
        end
        // warning shows one cycle before the fault
        @(posedge pclk);
        cond <= 13'h0100;
        step(1);
        check(33'(flags[7:6]), 33'h1); // warning first
        step(1);
        check(33'(flags[7:6]), 33'h3); // fault follows
        @(posedge pclk);
        cond <= 13'h0001;
        proc_cmd_start <= 1'b1;
        @(posedge pclk);
        proc_cmd_start <= 1'b0;
        proc_cmd_end <= 1'b1;
        #1;
        check(33'(flags[2:0]), 33'h0); // running
        @(posedge pclk);
        proc_cmd_end <= 1'b0;
        #1;
        check(33'(flags[2:0]), 33'h5); // done and in place
        @(posedge pclk);
        cond <= '0;
        step(2);
        check(33'(flags[2:0]), 33'h4); // one input only
        apb(1'b1, CTRL_OFFSET, '0);
        step(2);
        check(33'(flags[2:0]), 33'h0); // mode off
        // second reset in mid-run with a condition held
        @(posedge pclk);
        cond <= 13'h1010;
        step(2);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        check(33'({flags, do_pin}), 33'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        step(3);
        check(33'(flags), 33'h120); // back after reset
        wrap_up();
    end
endmodule : testbench
